// file: hw/psl_consts.svh
// Constants for the port status indicator driver.
// Assumes a 100 MHz reference clock and six shared indicator pins.
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// =============================================================
// Pins and function codes
`define PSL_PINS      6
`define PSL_FUN_STD   2'h0
`define PSL_FUN_SPLIT 2'h1
`define PSL_FUN_MII   2'h2
`define PSL_FUN_RAW   2'h3
`define PSL_LED0      3'h0
`define PSL_LED1      3'h1
`define PSL_LED2      3'h2
`define PSL_LED3      3'h3
`define PSL_LED4      3'h4
`define PSL_LED5      3'h5

// =============================================================
// Timing
`define PSL_CLK_NS    10
`define PSL_PULSE_NS  80000000
`define PSL_CNT_W     23
`define PSL_POL_RST   6'h00

`endif

// file: hw/psl_pkg.sv
// Types shared by the port status indicator driver.
// Assumes the constants header is compiled alongside.
package psl_pkg;

  // =============================================================
  // Per-pin stretch timer states.
  typedef enum logic [1:0] {
    PSL_IDLE  = 2'h0,
    PSL_PULSE = 2'h1,
    PSL_GAP   = 2'h3
  } psl_tmr_e;

  // =============================================================
  // Status of one internal copper port.
  typedef struct packed {
    logic link;
    logic spd100;
    logic full_dup;
    logic col;
    logic tx_en;
    logic rx_dv;
  } psl_phy_s;

  // Strobes of the external media-independent port.
  typedef struct packed {
    logic tx_en;
    logic rx_dv;
  } psl_mii_s;

  // Source description of one indicator pin.
  typedef struct packed {
    logic gate;
    logic steady;
    logic evt;
    logic blink_low;
    logic raw;
  } psl_src_s;

endpackage

// file: hw/psl_led_driver.sv
// Port status indicator driver for six shared indicator pins.
// Assumes status inputs are synchronous to i_ref_clk and the pad
// resolves each pin from its output and active-low output enable.

`include "psl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module psl_led_driver #(
  parameter int unsigned P_PULSE_CYC = `PSL_PULSE_NS / `PSL_CLK_NS
) (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rstn,
  // Configuration
  input  wire logic [1:0]              i_led_fun,
  input  wire logic [`PSL_PINS-1:0]    i_led_en,
  input  wire logic [`PSL_PINS-1:0]    i_pol_strap,
  // Port status
  input  wire psl_pkg::psl_mii_s       i_p0,
  input  wire psl_pkg::psl_phy_s       i_p1,
  input  wire psl_pkg::psl_phy_s       i_p2,
  // Pins
  output logic [`PSL_PINS-1:0]         o_led_out,
  output logic [`PSL_PINS-1:0]         o_led_oe_n,
  output logic [`PSL_PINS-1:0]         o_led_ibuf_dis
);

  localparam logic [`PSL_CNT_W-1:0] LAST = `PSL_CNT_W'(P_PULSE_CYC - 1);

  // =============================================================
  // Source selection
  typedef enum logic [2:0] {
    K_TX0, K_RX0, K_LA, K_DC, K_SP, K_LA100, K_LA10
  } psl_kind_e;

  function automatic psl_pkg::psl_src_s port_src(
    input psl_kind_e         kind,
    input psl_pkg::psl_mii_s p0,
    input psl_pkg::psl_phy_s p
  );
    psl_pkg::psl_src_s s;
    s = '0;
    unique case (kind)
      K_TX0: begin
        s.gate = 1'b1;
        s.evt  = p0.tx_en;
      end
      K_RX0: begin
        s.gate = 1'b1;
        s.evt  = p0.rx_dv;
      end
      K_LA: begin
        s.gate      = p.link;
        s.steady    = 1'b1;
        s.evt       = p.tx_en | p.rx_dv;
        s.blink_low = 1'b1;
      end
      K_DC: begin
        s.gate   = p.link;
        s.steady = p.full_dup;
        s.evt    = p.col & ~p.full_dup;
      end
      K_SP: begin
        s.gate   = p.link;
        s.steady = p.spd100;
      end
      K_LA100: begin
        s.gate      = p.link & p.spd100;
        s.steady    = 1'b1;
        s.evt       = p.tx_en | p.rx_dv;
        s.blink_low = 1'b1;
      end
      K_LA10: begin
        s.gate      = p.link & ~p.spd100;
        s.steady    = 1'b1;
        s.evt       = p.tx_en | p.rx_dv;
        s.blink_low = 1'b1;
      end
    endcase
    return s;
  endfunction

  // Returns the source of one pin for the given function code.
  function automatic psl_pkg::psl_src_s pin_src(
    input logic [1:0]        fun,
    input logic [2:0]        pin,
    input psl_pkg::psl_mii_s p0,
    input psl_pkg::psl_phy_s p1,
    input psl_pkg::psl_phy_s p2
  );
    psl_pkg::psl_src_s s;
    s = '0;
    unique case (fun)
      `PSL_FUN_STD: begin
        unique case (pin)
          `PSL_LED5: s = port_src(K_LA, p0, p2);
          `PSL_LED4: s = port_src(K_DC, p0, p2);
          `PSL_LED3: s = port_src(K_SP, p0, p2);
          `PSL_LED2: s = port_src(K_LA, p0, p1);
          `PSL_LED1: s = port_src(K_DC, p0, p1);
          default:   s = port_src(K_SP, p0, p1);
        endcase
      end
      `PSL_FUN_SPLIT: begin
        unique case (pin)
          `PSL_LED5: s = port_src(K_LA100, p0, p2);
          `PSL_LED4: s = port_src(K_DC, p0, p2);
          `PSL_LED3: s = port_src(K_LA10, p0, p2);
          `PSL_LED2: s = port_src(K_LA100, p0, p1);
          `PSL_LED1: s = port_src(K_DC, p0, p1);
          default:   s = port_src(K_LA10, p0, p1);
        endcase
      end
      `PSL_FUN_MII: begin
        unique case (pin)
          `PSL_LED5: s = port_src(K_TX0, p0, p2);
          `PSL_LED4: s = port_src(K_LA, p0, p2);
          `PSL_LED3: s = port_src(K_SP, p0, p2);
          `PSL_LED2: s = port_src(K_RX0, p0, p1);
          `PSL_LED1: s = port_src(K_LA, p0, p1);
          default:   s = port_src(K_SP, p0, p1);
        endcase
      end
      default: begin
        unique case (pin)
          `PSL_LED5: s.raw = p0.tx_en;
          `PSL_LED4: s.raw = p2.tx_en;
          `PSL_LED3: s.raw = p2.rx_dv;
          `PSL_LED2: s.raw = p0.rx_dv;
          `PSL_LED1: s.raw = p1.tx_en;
          default:   s.raw = p1.rx_dv;
        endcase
      end
    endcase
    return s;
  endfunction

  // =============================================================
  // Polarity strap capture
  logic [`PSL_PINS-1:0] pol_reg;
  logic                 latched_reg;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pol_reg     <= `PSL_POL_RST;
      latched_reg <= 1'b0;
    end else if (!latched_reg) begin
      pol_reg     <= i_pol_strap;
      latched_reg <= 1'b1;
    end
  end

  // =============================================================
  // Per-pin decode
  psl_pkg::psl_src_s    src [`PSL_PINS];
  logic [`PSL_PINS-1:0] trig;
  logic [`PSL_PINS-1:0] act_vec;
  logic [`PSL_PINS-1:0] raw_vec;
  psl_pkg::psl_tmr_e    st_reg  [`PSL_PINS];
  logic [`PSL_CNT_W-1:0] cnt_reg [`PSL_PINS];

  always_comb begin
    for (int i = 0; i < `PSL_PINS; i++) begin
      src[i]     = pin_src(i_led_fun, 3'(i), i_p0, i_p1, i_p2);
      trig[i]    = src[i].gate & src[i].evt;
      raw_vec[i] = src[i].raw;
      if (src[i].blink_low) begin
        act_vec[i] = src[i].gate & src[i].steady & (st_reg[i] != psl_pkg::PSL_PULSE);
      end else begin
        act_vec[i] = src[i].gate & (src[i].steady | (st_reg[i] == psl_pkg::PSL_PULSE));
      end
    end
  end

  // =============================================================
  // Stretch timers
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < `PSL_PINS; i++) begin
        st_reg[i]  <= psl_pkg::PSL_IDLE;
        cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `PSL_PINS; i++) begin
        if (!i_led_en[i] || i_led_fun == `PSL_FUN_RAW) begin
          st_reg[i]  <= psl_pkg::PSL_IDLE;
          cnt_reg[i] <= '0;
        end else begin
          unique case (st_reg[i])
            psl_pkg::PSL_IDLE: begin
              if (trig[i]) begin
                st_reg[i]  <= psl_pkg::PSL_PULSE;
                cnt_reg[i] <= LAST;
              end
            end
            psl_pkg::PSL_PULSE: begin
              if (cnt_reg[i] == '0) begin
                st_reg[i]  <= psl_pkg::PSL_GAP;
                cnt_reg[i] <= LAST;
              end else begin
                cnt_reg[i] <= cnt_reg[i] - 1'b1;
              end
            end
            psl_pkg::PSL_GAP: begin
              if (cnt_reg[i] == '0) begin
                st_reg[i] <= psl_pkg::PSL_IDLE;
              end else begin
                cnt_reg[i] <= cnt_reg[i] - 1'b1;
              end
            end
            default: begin
              st_reg[i]  <= psl_pkg::PSL_IDLE;
              cnt_reg[i] <= '0;
            end
          endcase
        end
      end
    end
  end

  // =============================================================
  // Pin drivers
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_led_out      <= '0;
      o_led_oe_n     <= '1;
      o_led_ibuf_dis <= '0;
    end else begin
      o_led_ibuf_dis <= i_led_en;
      for (int i = 0; i < `PSL_PINS; i++) begin
        if (!i_led_en[i]) begin
          o_led_out[i]  <= 1'b0;
          o_led_oe_n[i] <= 1'b1;
        end else if (i_led_fun == `PSL_FUN_RAW) begin
          o_led_out[i]  <= raw_vec[i];
          o_led_oe_n[i] <= 1'b0;
        end else begin
          o_led_out[i]  <= ~pol_reg[i];
          o_led_oe_n[i] <= ~act_vec[i];
        end
      end
    end
  end

  // =============================================================
  // Checks
  wire logic std_mode = (i_led_fun != `PSL_FUN_RAW);

  a_active_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    latched_reg && std_mode |=> ((~o_led_oe_n & (o_led_out ~^ pol_reg)) == '0))
    else $error("active pin not at inverse strap level");

  a_inactive_float: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    std_mode |=> (o_led_oe_n == ~$past(act_vec & i_led_en)))
    else $error("inactive pin is driven");

  a_pol_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    latched_reg |=> $stable(pol_reg))
    else $error("polarity changed after capture");

  a_ibuf_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> (o_led_ibuf_dis == $past(i_led_en)))
    else $error("input buffer not disabled on indicator pin");

  a_raw_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !std_mode |=> ((o_led_oe_n | ~$past(i_led_en)) == ~$past(i_led_en)) &&
                  (((o_led_out ^ $past(raw_vec)) & $past(i_led_en)) == '0))
    else $error("raw mode pin not copying its strobe");

  a_link_blank: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_led_fun == `PSL_FUN_STD) && !i_p2.link && i_led_en[5] && i_led_en[3]
      |=> o_led_oe_n[5] && o_led_oe_n[3])
    else $error("link indicator active without link");

  a_tx_nolink: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_led_fun == `PSL_FUN_MII) && i_led_en[5] && (st_reg[5] == psl_pkg::PSL_PULSE)
      |=> !o_led_oe_n[5])
    else $error("transmit pulse blocked");

  a_full_dup_on: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_led_fun == `PSL_FUN_STD) && i_led_en[`PSL_LED1] && i_p1.link && i_p1.full_dup
      |=> !o_led_oe_n[`PSL_LED1])
    else $error("full duplex indicator not active");

  a_fast_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_led_fun == `PSL_FUN_SPLIT) && i_led_en[`PSL_LED5] && !i_p2.spd100
      |=> o_led_oe_n[`PSL_LED5])
    else $error("fast link indicator active at low speed");

  a_slow_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_led_fun == `PSL_FUN_SPLIT) && i_led_en[`PSL_LED3] && i_p2.spd100
      |=> o_led_oe_n[`PSL_LED3])
    else $error("slow link indicator active at high speed");

  a_push_pull: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !std_mode |=> ((o_led_oe_n & $past(i_led_en)) == '0))
    else $error("raw mode pin not driven");

  a_gpio_free: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> ((~o_led_oe_n & ~$past(i_led_en)) == '0))
    else $error("disabled pin is driven");

  for (genvar g = 0; g < `PSL_PINS; g++) begin : g_chk
    sequence s_pulse_load;
      (st_reg[g] == psl_pkg::PSL_PULSE) && (cnt_reg[g] == LAST);
    endsequence
    sequence s_gap_load;
      (st_reg[g] == psl_pkg::PSL_GAP) && (cnt_reg[g] == LAST);
    endsequence

    a_pulse_start: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      std_mode && i_led_en[g] && (st_reg[g] == psl_pkg::PSL_IDLE) && trig[g] |=> s_pulse_load)
      else $error("pulse did not start on event");

    a_pulse_end: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      std_mode && i_led_en[g] && (st_reg[g] == psl_pkg::PSL_PULSE) && (cnt_reg[g] == '0)
        |=> s_gap_load)
      else $error("pulse did not hand over to gap");

    a_gap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      std_mode && i_led_en[g] && (st_reg[g] == psl_pkg::PSL_GAP) && (cnt_reg[g] != '0)
        |=> (st_reg[g] == psl_pkg::PSL_GAP) && (cnt_reg[g] == $past(cnt_reg[g]) - 1'b1))
      else $error("gap cut short");
  end

endmodule

`default_nettype wire

// file: dv/psl_led_board.sv
// Board model of the indicator pins and their strap resistors.
// Assumes the driver's active-low output enable on each pin.
`include "psl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module psl_led_board #(
  parameter logic [`PSL_PINS-1:0] P_STRAP = 6'h2a
) (
  // Pads from the driver
  input  wire logic [`PSL_PINS-1:0] i_led_out,
  input  wire logic [`PSL_PINS-1:0] i_led_oe_n,
  // Resolved pin levels
  output logic [`PSL_PINS-1:0]      o_pin
);
  // =============================================================
  // Pin resolution
  // An undriven pin rests at the level of its strap resistor.
  always_comb begin
    for (int i = 0; i < `PSL_PINS; i++) begin
      o_pin[i] = i_led_oe_n[i] ? P_STRAP[i] : i_led_out[i];
    end
  end
endmodule

`default_nettype wire

// file: dv/psl_tb.sv
// Self-checking bench of the indicator driver with a short pulse.
// Assumes the board model and the driver are compiled beforehand.
`include "psl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int unsigned N     = 20;
  localparam logic [5:0]  STRAP = 6'h2a;
  logic              i_ref_clk = 1'b0;
  logic              i_rstn    = 1'b0;
  logic [1:0]        i_led_fun;
  logic [5:0]        i_led_en;
  logic [5:0]        i_pol_strap;
  psl_pkg::psl_mii_s i_p0;
  psl_pkg::psl_phy_s i_p1;
  psl_pkg::psl_phy_s i_p2;
  logic [5:0]        o_led_out;
  logic [5:0]        o_led_oe_n;
  logic [5:0]        o_led_ibuf_dis;
  logic [5:0]        pin;
  int                failures   = 0;
  int                num_checks = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  psl_led_driver #(.P_PULSE_CYC(N)) dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_led_fun(i_led_fun),
    .i_led_en(i_led_en), .i_pol_strap(i_pol_strap), .i_p0(i_p0),
    .i_p1(i_p1), .i_p2(i_p2), .o_led_out(o_led_out),
    .o_led_oe_n(o_led_oe_n), .o_led_ibuf_dis(o_led_ibuf_dis)
  );

  psl_led_board #(.P_STRAP(STRAP)) board (
    .i_led_out(o_led_out), .i_led_oe_n(o_led_oe_n), .o_pin(pin)
  );

  // =============================================================
  // Shared tasks
  task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Active pins are driven to the inverse of the strap latched on the first clock after reset.
  task automatic expect_pin(input int p, input logic act);
    chk("oe_n", 6'(o_led_oe_n[p]), 6'(!act));
    chk("pin", 6'(pin[p]), 6'(STRAP[p] ^ act));
  endtask

  // Indexes follow the raw mode pin order; 6 is the port 1 collision.
  task automatic set_evt(input int k, input logic v);
    case (k)
      0: i_p1.rx_dv <= v;
      1: i_p1.tx_en <= v;
      2: i_p0.rx_dv <= v;
      3: i_p2.rx_dv <= v;
      4: i_p2.tx_en <= v;
      5: i_p0.tx_en <= v;
      default: i_p1.col <= v;
    endcase
  endtask

  task automatic fire(input int k);
    @(posedge i_ref_clk);
    set_evt(k, 1'b1);
    @(posedge i_ref_clk);
    set_evt(k, 1'b0);
  endtask

  task automatic setup(input logic [1:0] f, input logic [5:0] en, input logic [5:0] a, input logic [5:0] b);
    @(posedge i_ref_clk);
    i_led_fun <= f;
    i_led_en  <= en;
    i_p1      <= a;
    i_p2      <= b;
    tick(3);
  endtask

  // Pulse, ignored retrigger in the gap, then a fresh pulse after it.
  task automatic blink(input int p, input int k, input logic low);
    fire(k);
    tick(3);
    expect_pin(p, !low);
    tick(N);
    expect_pin(p, low);
    fire(k);
    tick(3);
    expect_pin(p, low);
    tick(N);
    fire(k);
    tick(3);
    expect_pin(p, !low);
    tick(2 * N + 4);
  endtask

  // =============================================================
  // Scenarios
  task automatic t_std();
    setup(2'h0, 6'h3f, 6'h38, 6'h20);
    expect_pin(0, 1'b1);
    expect_pin(1, 1'b1);
    expect_pin(2, 1'b1);
    expect_pin(3, 1'b0);
    expect_pin(4, 1'b0);
    expect_pin(5, 1'b1);
    chk("ibuf", o_led_ibuf_dis, 6'h3f);
    setup(2'h0, 6'h3f, 6'h18, 6'h20);
    chk("nolink oe_n", o_led_oe_n & 6'h07, 6'h07);
    setup(2'h0, 6'h3f, 6'h20, 6'h20);
    blink(1, 6, 1'b0);
    blink(2, 1, 1'b1);
    $display("t_std done");
  endtask

  task automatic t_split();
    setup(2'h1, 6'h3f, 6'h20, 6'h30);
    expect_pin(5, 1'b1);
    expect_pin(3, 1'b0);
    expect_pin(2, 1'b0);
    expect_pin(0, 1'b1);
    blink(5, 4, 1'b1);
    blink(0, 0, 1'b1);
    setup(2'h1, 6'h3f, 6'h20, 6'h10);
    expect_pin(5, 1'b0);
    $display("t_split done");
  endtask

  task automatic t_port0();
    setup(2'h2, 6'h3f, 6'h00, 6'h00);
    blink(5, 5, 1'b0);
    blink(2, 2, 1'b0);
    $display("t_port0 done");
  endtask

  task automatic t_raw();
    setup(2'h3, 6'h3f, 6'h00, 6'h00);
    for (int p = 0; p < 6; p++) begin
      @(posedge i_ref_clk);
      set_evt(p, 1'b1);
      tick(3);
      chk("raw out", o_led_out, 6'h01 << p);
      chk("raw oe_n", o_led_oe_n, 6'h00);
      chk("raw pin", pin, 6'h01 << p);
      @(posedge i_ref_clk);
      set_evt(p, 1'b0);
    end
    tick(3);
    chk("raw low", o_led_out, 6'h00);
    $display("t_raw done");
  endtask

  task automatic t_disable();
    setup(2'h0, 6'h0f, 6'h38, 6'h20);
    chk("ibuf", o_led_ibuf_dis, 6'h0f);
    expect_pin(5, 1'b0);
    expect_pin(0, 1'b1);
    setup(2'h0, 6'h00, 6'h38, 6'h20);
    chk("off oe_n", o_led_oe_n, 6'h3f);
    $display("t_disable done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // =============================================================
  // Main sequence
  initial begin
    i_led_fun   = 2'h0;
    i_led_en    = 6'h00;
    i_pol_strap = STRAP;
    i_p0        = '0;
    i_p1        = '0;
    i_p2        = '0;
    tick(15);
    chk("rst oe_n", o_led_oe_n, 6'h3f);
    chk("rst ibuf", o_led_ibuf_dis, 6'h00);
    @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    tick(2);
    @(posedge i_ref_clk);
    i_pol_strap <= ~STRAP;
    t_std();
    t_split();
    t_port0();
    t_raw();
    t_disable();
    summarize();
  end
endmodule

`default_nettype wire
